/* logic/ctm_timer.sv */
`timescale 1ns/1ns
// What this block does
// - Ten-bit counter counts up on selected edges
// - Period match compares next count's top three bits, low seven zero
// - Compare A matches all ten counter bits
// - Software clears counter only via enable rise
// - Counter clears on overflow or chosen match
// - Separate compare A and period interrupts
// - External pin counts on rising or falling
// - Second output pin is inverse of first
// - Compare mode sets, clears or toggles output
// - PWM drives the same output pin pair
// - Only compare, timer and PWM modes exist
// - Low bytes go through shared byte buffer
// - Compare low write buffers; high commits both
// - High byte read latches low into buffer
// - Counter read-only, compare read/write, period
// - Clock select picks system, divided, sub or pin
// - Period zero means 1024, else n*128
// - Enable rise clears, fall holds counter
// - Mode field: 00 compare, 10 PWM, 11 timer
module ctm_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Internal clock ticks from the clock tree, one clk cycle wide
  input  wire logic       tick_sys,
  input  wire logic       tick_high,
  input  wire logic       tick_sub,
  // External count pin, asynchronous
  input  wire logic       ext_count_clock_pin,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Pins and events
  output logic            timer_output_pin,
  output logic            timer_output_inverted_pin,
  output logic            irq_compare_a,
  output logic            irq_period
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [9:0] cmpa_r;
  logic [7:0] buf_r;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic       en_d_r;
  logic [5:0] div_sys_r;
  logic [5:0] div_h_r;
  logic       pin_s1_r;
  logic       pin_s2_r;
  logic       pin_s3_r;
  logic       out_r;
  logic       out_nxt;
  logic       tick;
  logic       match_a;
  logic       match_p;
  logic       wr_hit;
  logic       en_rise;
  logic [9:0] cnt_inc;

  wire [2:0] cks    = ctrl_a_r[ctm_pkg::CA_CKS_HI:ctm_pkg::CA_CKS_LO];
  wire [2:0] period = ctrl_a_r[ctm_pkg::CA_PER_HI:ctm_pkg::CA_PER_LO];
  wire       enable = ctrl_a_r[ctm_pkg::CA_ENABLE];
  wire       pause  = ctrl_a_r[ctm_pkg::CA_PAUSE];
  wire [1:0] mode   = ctrl_b_r[ctm_pkg::CB_MODE_HI:ctm_pkg::CB_MODE_LO];
  wire [1:0] io_sel = ctrl_b_r[ctm_pkg::CB_IO_HI:ctm_pkg::CB_IO_LO];
  wire       init   = ctrl_b_r[ctm_pkg::CB_INIT];
  wire       pol    = ctrl_b_r[ctm_pkg::CB_POL];
  wire       dpx    = ctrl_b_r[ctm_pkg::CB_DPX];
  wire       cclr   = ctrl_b_r[ctm_pkg::CB_CCLR];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_a_r <= ctm_pkg::CTRL_A_RST;
      ctrl_b_r <= ctm_pkg::CTRL_B_RST;
      cmpa_r   <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ctm_pkg::ADDR_CTRL_A:  ctrl_a_r <= reg_wdata;
        ctm_pkg::ADDR_CTRL_B:  ctrl_b_r <= reg_wdata;
        ctm_pkg::ADDR_CMPA_HI: cmpa_r   <= {reg_wdata[1:0], buf_r};
        default: ;
      endcase
    end
  end

  // Shared low-byte buffer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      buf_r <= '0;
    else if (reg_wr && reg_addr == ctm_pkg::ADDR_CMPA_LO)
      buf_r <= reg_wdata;
    else if (reg_rd && reg_addr == ctm_pkg::ADDR_CNT_HI)
      buf_r <= cnt_r[7:0];
    else if (reg_rd && reg_addr == ctm_pkg::ADDR_CMPA_HI)
      buf_r <= cmpa_r[7:0];
  end

  // Read data; counter pair has no write path at all
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ctm_pkg::ADDR_CTRL_A:  reg_rdata <= ctrl_a_r;
        ctm_pkg::ADDR_CTRL_B:  reg_rdata <= ctrl_b_r;
        ctm_pkg::ADDR_CNT_LO:  reg_rdata <= buf_r;
        ctm_pkg::ADDR_CNT_HI:  reg_rdata <= {6'h00, cnt_r[9:8]};
        ctm_pkg::ADDR_CMPA_LO: reg_rdata <= buf_r;
        ctm_pkg::ADDR_CMPA_HI: reg_rdata <= {6'h00, cmpa_r[9:8]};
        default:               reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source: prescalers and pin edge detect
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_sys_r <= '0;
      div_h_r   <= '0;
    end
    else
    begin
      if (tick_sys)
        div_sys_r <= div_sys_r + 6'h01;
      if (tick_high)
        div_h_r <= div_h_r + 6'h01;
    end
  end

  // The pin is asynchronous; s3 only follows s2 for edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= ext_count_clock_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_comb
  begin
    unique case (cks)
      ctm_pkg::CKS_SYS_DIV4:
        tick = tick_sys && (div_sys_r[1:0] == ctm_pkg::PRESC_DIV4[1:0]);
      ctm_pkg::CKS_SYS:      tick = tick_sys;
      ctm_pkg::CKS_H_DIV16:
        tick = tick_high && (div_h_r[3:0] == ctm_pkg::PRESC_DIV16[3:0]);
      ctm_pkg::CKS_H_DIV64:
        tick = tick_high && (div_h_r == ctm_pkg::PRESC_DIV64);
      ctm_pkg::CKS_SUB_A,
      ctm_pkg::CKS_SUB_B:    tick = tick_sub;
      ctm_pkg::CKS_PIN_RISE: tick = pin_s2_r && !pin_s3_r;
      default:               tick = !pin_s2_r && pin_s3_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators
  // Comparator P watches the count about to be reached, so the clear
  // lands after exactly n*128 ticks; period zero then falls on the wrap
  assign cnt_inc = cnt_r + 10'h001;
  assign match_p = (cnt_inc[9:7] == period)
                   && (cnt_inc[6:0] == 7'h00);
  assign match_a = (cnt_r == cmpa_r);
  assign wr_hit  = reg_wr && reg_addr == ctm_pkg::ADDR_CTRL_A;
  assign en_rise = enable && !en_d_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      en_d_r <= 1'b0;
    else
      en_d_r <= enable;
  end

  wire wrap     = (cnt_r == ctm_pkg::CNT_MAX);
  wire p_event  = match_p;
  wire a_event  = match_a;
  wire clr_pwm  = dpx ? a_event : p_event;
  wire clr_sel  = (mode == ctm_pkg::MODE_PWM) ? clr_pwm :
                  (cclr ? a_event : p_event);
  // No count on the enable rise itself: that edge only clears, so a
  // stale match value left from the last run raises no interrupt
  wire run      = enable && en_d_r && !pause && tick;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (en_rise)
      cnt_nxt = '0;
    else if (run)
    begin
      if (clr_sel || wrap)
        cnt_nxt = '0;
      else
        cnt_nxt = cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // One-cycle interrupts on the count edge that sees the match
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_compare_a <= 1'b0;
      irq_period    <= 1'b0;
    end
    else
    begin
      irq_compare_a <= run && a_event;
      irq_period    <= run && p_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin logic; timer mode holds the output apart from the init load on enable rise
  wire [9:0] duty_val = dpx ? {period, 7'h00} : cmpa_r;

  always_comb
  begin
    out_nxt = out_r;
    if (en_rise)
      out_nxt = (mode == ctm_pkg::MODE_PWM) ? !init : init;
    else if (mode == ctm_pkg::MODE_CMP && run && a_event)
    begin
      unique case (io_sel)
        ctm_pkg::IO_NONE: out_nxt = out_r;
        ctm_pkg::IO_LOW:  out_nxt = 1'b0;
        ctm_pkg::IO_HIGH: out_nxt = 1'b1;
        default:          out_nxt = !out_r;
      endcase
    end
    else if (mode == ctm_pkg::MODE_PWM && enable)
    begin
      unique case (io_sel)
        ctm_pkg::IO_NONE: out_nxt = !init;
        ctm_pkg::IO_LOW:  out_nxt = init;
        ctm_pkg::IO_HIGH: out_nxt = (cnt_nxt < duty_val) ? init : !init;
        default:          out_nxt = out_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      out_r <= 1'b0;
    else
      out_r <= out_nxt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_output_pin          <= 1'b0;
      timer_output_inverted_pin <= 1'b1;
    end
    else
    begin
      timer_output_pin          <= out_nxt ^ pol;
      timer_output_inverted_pin <= !(out_nxt ^ pol);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_pin_inverse: assert property (
    @(posedge clk) disable iff (!arst_n)
    timer_output_inverted_pin == !timer_output_pin)
    else $error("inverted pin not inverse");

  chk_enable_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(enable) |=> cnt_r == 10'h000)
    else $error("counter not cleared on enable rise");

  chk_hold_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!enable && en_d_r) ##1 !enable |-> $stable(cnt_r))
    else $error("counter moved while off");

  chk_count_up: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && !en_rise && !clr_sel && !wrap |=> cnt_r == $past(cnt_r) + 10'h001)
    else $error("counter did not advance");

  chk_irq_a_pulse: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && match_a |=> irq_compare_a ##1 !irq_compare_a)
    else $error("compare A irq not one pulse");

  chk_irq_p_cause: assert property (
    @(posedge clk) disable iff (!arst_n)
    irq_period |-> $past(run)
      && $past(cnt_r) + 10'h001 == {$past(period), 7'h00})
    else $error("period irq without match");

  chk_cmpa_commit: assert property (
    @(posedge clk) disable iff (!arst_n)
    reg_wr && reg_addr == ctm_pkg::ADDR_CMPA_HI
      |=> cmpa_r == {$past(reg_wdata[1:0]), $past(buf_r)})
    else $error("compare A commit wrong");

  chk_hi_latch: assert property (
    @(posedge clk) disable iff (!arst_n)
    reg_rd && reg_addr == ctm_pkg::ADDR_CNT_HI
      |=> buf_r == $past(cnt_r[7:0]))
    else $error("buffer not latched on high read");

  chk_match_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && !en_rise && mode == ctm_pkg::MODE_CMP && cclr && match_a
      |=> cnt_r == 10'h000)
    else $error("counter not cleared on A match");

  chk_period_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    run && mode == ctm_pkg::MODE_TIMER && !cclr && p_event
      |=> cnt_r == 10'h000)
    else $error("counter not cleared on period match");

  chk_timer_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    enable && en_d_r && mode == ctm_pkg::MODE_TIMER && $stable(ctrl_b_r)
      |=> $stable(timer_output_pin))
    else $error("output moved in timer mode");

  cov_irq_a:  cover property (@(posedge clk) disable iff (!arst_n)
    irq_compare_a);
  cov_irq_p:  cover property (@(posedge clk) disable iff (!arst_n)
    irq_period);
  cov_toggle: cover property (@(posedge clk) disable iff (!arst_n)
    mode == ctm_pkg::MODE_CMP && $changed(timer_output_pin));
  cov_pwm:    cover property (@(posedge clk) disable iff (!arst_n)
    mode == ctm_pkg::MODE_PWM && $rose(timer_output_pin));

endmodule // ctm_timer

/* logic/ctm_pkg.sv */
package ctm_pkg;

  // Register indices on the byte-wide register port
  localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO  = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI  = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;

  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;

  // timer_control_a fields
  localparam int CA_PAUSE   = 7;
  localparam int CA_CKS_HI  = 6;
  localparam int CA_CKS_LO  = 4;
  localparam int CA_ENABLE  = 3;
  localparam int CA_PER_HI  = 2;
  localparam int CA_PER_LO  = 0;

  // timer_control_b fields
  localparam int CB_MODE_HI = 7;
  localparam int CB_MODE_LO = 6;
  localparam int CB_IO_HI   = 5;
  localparam int CB_IO_LO   = 4;
  localparam int CB_INIT    = 3;
  localparam int CB_POL     = 2;
  localparam int CB_DPX     = 1;
  localparam int CB_CCLR    = 0;

  // Mode encodings
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  // Output action encodings
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW  = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOG  = 2'h3;

  // Clock select encodings
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS      = 3'h1;
  localparam logic [2:0] CKS_H_DIV16  = 3'h2;
  localparam logic [2:0] CKS_H_DIV64  = 3'h3;
  localparam logic [2:0] CKS_SUB_A    = 3'h4;
  localparam logic [2:0] CKS_SUB_B    = 3'h5;
  localparam logic [2:0] CKS_PIN_RISE = 3'h6;
  localparam logic [2:0] CKS_PIN_FALL = 3'h7;

  localparam logic [5:0] PRESC_DIV4  = 6'h03;
  localparam logic [5:0] PRESC_DIV16 = 6'h0F;
  localparam logic [5:0] PRESC_DIV64 = 6'h3F;

  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_MAX = 10'h3FF;

endpackage

/* tb/ctm_pin_model.sv */
`timescale 1ns/1ns
// Far side: drives the external count pin in bursts of whole pulses
module ctm_pin_model (
  // Clock
  input  wire logic       clk,
  // Burst request
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  // Pin and status
  output logic            ext_pin,
  output logic            busy
);
  initial
  begin
    ext_pin = 1'b0;
    busy    = 1'b0;
    forever
    begin
      @(posedge clk);
      if (start)
      begin
        busy <= 1'b1;
        repeat (pulses)
        begin
          // Varying widths stress the pin synchronizer
          repeat (2 + $urandom % 4) @(posedge clk);
          ext_pin <= 1'b1;
          repeat (2 + $urandom % 4) @(posedge clk);
          ext_pin <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // ctm_pin_model

/* tb/tb_compact_timer_module_10bit.sv */
`timescale 1ns/1ns
module tb_compact_timer_module_10bit;
  logic       clk, arst_n, tick_sys, tick_sub, tick_high, reg_wr, reg_rd;
  logic       out, out_n, irq_a, irq_p, pin, m_start, m_busy;
  logic       rd_seen, have_prev, e1;
  logic [2:0] reg_addr, per, cks;
  logic [7:0] reg_wdata, reg_rdata, m_pulses;
  logic [9:0] cv, n;
  int         bad_count, comparisons, gap, hc, j, pg, dv;
  logic [7:0] rd_q[$];
  logic       pin_q[$];
  int         gap_q[$];

  ctm_timer i_dut (.clk(clk), .arst_n(arst_n), .tick_sys(tick_sys),
    .tick_high(tick_high), .tick_sub(tick_sub), .ext_count_clock_pin(pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_output_pin(out),
    .timer_output_inverted_pin(out_n), .irq_compare_a(irq_a),
    .irq_period(irq_p));
  ctm_pin_model i_pin (.clk(clk), .start(m_start), .pulses(m_pulses),
    .ext_pin(pin), .busy(m_busy));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  task check_rd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: read %h want %h", $time, got, exp);
    end
  endtask

  task check_ev(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %0d want %0d", $time, got, exp);
    end
  endtask

  task give_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Strobes persist until the next call, so calls may run back to back
  task bus(input logic w, r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task rd(input logic [2:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task idle;
    bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  task wait_empty;
    for (hc = 0; hc < 4000 && (pin_q.size() + gap_q.size()) > 0; hc++)
      @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge clk) rd_seen <= reg_rd;

  // Sampled mid-cycle, where registered results have settled
  always @(negedge clk)
  begin
    if (rd_seen) check_rd(reg_rdata, rd_q.pop_front());
    if (arst_n) check_ev(out_n, {~out});
    if (irq_a && pin_q.size() > 0) check_ev(out, pin_q.pop_front());
    gap++;
    if (irq_p)
    begin
      if (have_prev && gap_q.size() > 0)
        check_ev(gap, gap_q.pop_front());
      have_prev = gap_q.size() > 0;
      gap = 0;
    end
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hFD00));
    {arst_n, tick_sys, tick_sub, tick_high, reg_wr, reg_rd, m_start} = 7'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    m_pulses = 8'h00;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    tick_sys <= 1'b1;
    for (j = 0; j < 8; j++) rd(3'(j), 8'h00);
    cv = 10'($urandom);
    wr(ctm_pkg::ADDR_CTRL_A, cv[7:0] & 8'hF7);
    wr(ctm_pkg::ADDR_CTRL_B, ~cv[7:0]);
    rd(ctm_pkg::ADDR_CTRL_A, cv[7:0] & 8'hF7);
    rd(ctm_pkg::ADDR_CTRL_B, ~cv[7:0]);
    wr(ctm_pkg::ADDR_CMPA_LO, cv[7:0]);
    wr(ctm_pkg::ADDR_CMPA_HI, {6'h2A, cv[9:8]});
    rd(ctm_pkg::ADDR_CMPA_HI, {6'h00, cv[9:8]});
    rd(ctm_pkg::ADDR_CMPA_LO, cv[7:0]);
    wr(ctm_pkg::ADDR_CMPA_LO, ~cv[7:0]);
    rd(ctm_pkg::ADDR_CMPA_HI, {6'h00, cv[9:8]});
    rd(ctm_pkg::ADDR_CMPA_LO, cv[7:0]);
    // Compare-A match every 4 ticks; each output action from its start
    wr(ctm_pkg::ADDR_CMPA_LO, 8'h03);
    wr(ctm_pkg::ADDR_CMPA_HI, 8'h00);
    for (j = 0; j < 4; j++)
    begin
      wr(ctm_pkg::ADDR_CTRL_B, {ctm_pkg::MODE_CMP, 2'(j), j[0], 3'b001});
      pin_q = {j == 2, j >= 2};
      wr(ctm_pkg::ADDR_CTRL_A, {1'b0, ctm_pkg::CKS_SYS, 1'b1, 3'h0});
      idle;
      wait_empty;
      wr(ctm_pkg::ADDR_CTRL_A, 8'h10);
    end
    wr(ctm_pkg::ADDR_CTRL_B, {ctm_pkg::MODE_TIMER, 6'h00});
    for (j = 0; j < 3; j++)
    begin
      per = j == 0 ? 3'h0 : j == 1 ? 3'h1 : 3'(2 + $urandom % 6);
      pg = per == 0 ? 1024 : int'(per) * 128;
      gap_q = {pg, pg};
      wr(ctm_pkg::ADDR_CTRL_A, {1'b0, ctm_pkg::CKS_SYS, 1'b1, per});
      idle;
      wait_empty;
      wr(ctm_pkg::ADDR_CTRL_A, 8'h10);
    end
    // Tick sources get 64 source pulses, an exact count whatever the prescaler phase; pin sources get 1 to 40 pulses
    for (j = 0; j < 7; j++)
    begin
      cks = j == 0 ? ctm_pkg::CKS_PIN_RISE : j == 1 ? ctm_pkg::CKS_PIN_FALL
          : j == 2 ? ctm_pkg::CKS_SUB_A : j == 3 ? ctm_pkg::CKS_SUB_B
          : j == 4 ? ctm_pkg::CKS_SYS_DIV4 : j == 5 ? ctm_pkg::CKS_H_DIV16
          : ctm_pkg::CKS_H_DIV64;
      dv = j == 4 ? 4 : j == 5 ? 16 : j == 6 ? 64 : 1;
      n = j < 2 ? 10'(1 + $urandom % 40) : 10'(64 / dv);
      tick_sys <= j != 4;
      wr(ctm_pkg::ADDR_CTRL_A, {1'b0, cks, 1'b1, 3'h0});
      idle;
      @(posedge clk);
      if (j < 2)
      begin
        m_pulses <= n[7:0];
        m_start <= 1'b1;
        @(posedge clk);
        m_start <= 1'b0;
        @(posedge clk);
        for (hc = 0; hc < 2000 && m_busy; hc++) @(posedge clk);
        repeat (6) @(posedge clk);
      end
      else
      begin
        hc = 0;
        while (hc < 64)
        begin
          @(posedge clk);
          e1 = 1'($urandom);
          hc += int'(e1);
          tick_sub <= e1 && j < 4;
          tick_high <= e1 && j > 4;
          if (j == 4)
            tick_sys <= e1;
        end
        @(posedge clk);
        tick_sub <= 1'b0;
        tick_high <= 1'b0;
        if (j == 4)
          tick_sys <= 1'b0;
      end
      wr(ctm_pkg::ADDR_CTRL_A, {1'b0, cks, 1'b0, 3'h0});
      wr(ctm_pkg::ADDR_CNT_HI, 8'hFF);
      wr(ctm_pkg::ADDR_CNT_LO, 8'hFF);
      rd(ctm_pkg::ADDR_CNT_HI, {6'h00, n[9:8]});
      rd(ctm_pkg::ADDR_CNT_LO, n[7:0]);
    end
    wr(ctm_pkg::ADDR_CTRL_A, {1'b0, ctm_pkg::CKS_PIN_RISE, 1'b1, 3'h0});
    wr(ctm_pkg::ADDR_CTRL_A, 8'h00);
    rd(ctm_pkg::ADDR_CNT_HI, 8'h00);
    rd(ctm_pkg::ADDR_CNT_LO, 8'h00);
    // PWM: period 128 ticks, duty 32, active high
    wr(ctm_pkg::ADDR_CMPA_LO, 8'h20);
    wr(ctm_pkg::ADDR_CMPA_HI, 8'h00);
    wr(ctm_pkg::ADDR_CTRL_B, {ctm_pkg::MODE_PWM, 2'h2, 1'b1, 3'b000});
    wr(ctm_pkg::ADDR_CTRL_A, {1'b0, ctm_pkg::CKS_SYS, 1'b1, 3'h1});
    idle;
    repeat (300) @(posedge clk);
    hc = 0;
    repeat (256)
    begin
      @(negedge clk);
      hc += int'(out);
    end
    check_ev(hc, 64);
    wr(ctm_pkg::ADDR_CTRL_A, 8'h00);
    idle;
    repeat (2) @(posedge clk);
    check_ev(pin_q.size() + gap_q.size() + rd_q.size(), 0);
    give_verdict;
  end
endmodule // tb_compact_timer_module_10bit
